// [rtl/hpt_defines.svh]
// Offsets, field positions, reset values and timing for the hot pin timer
`ifndef HPT_DEFINES_SVH
`define HPT_DEFINES_SVH

`define HPT_CLK_MHZ 20.0
`define HPT_TIMER_LSB_MS 22.76

`define HPT_ADDR_STATUS2 8'h42
`define HPT_ADDR_MASK2 8'h75
`define HPT_ADDR_CONFIG3 8'h78
`define HPT_ADDR_TIMER 8'h79
`define HPT_ADDR_LIMIT 8'h7A
`define HPT_ADDR_VPIN_SEL 8'h7D

`define HPT_MASK2_RST 8'h00
`define HPT_CONFIG3_RST 8'h00
`define HPT_LIMIT_RST 8'h00
`define HPT_VPIN_SEL_RST 8'h00
`define HPT_STATUS2_RST 8'h00

`define HPT_C3_ALERT_EN 0
`define HPT_C3_HOT_EN 1
`define HPT_C3_BOOST 2
`define HPT_VP_ALERT_EN 0

`define HPT_ST_DIODE2 7
`define HPT_ST_DIODE1 6
`define HPT_ST_FAN_FOUR_HOT 5
`define HPT_ST_FAN_THREE 4
`define HPT_ST_FAN_TWO 3
`define HPT_ST_FAN_ONE 2
`define HPT_ST_OVERTEMP 1

`define HPT_TIMER_FULL 8'hFF
`define HPT_TIMER_FIRST 8'h01
`define HPT_TIMER_STEP_UNITS 8'h02
`define HPT_DUTY_OFF 8'h00

`endif

// [rtl/hpt_pkg.sv]
// Types shared by the hot pin timer and alert logic
package hpt_pkg;

    typedef struct packed {
        logic diode_two;
        logic diode_one;
        logic fan_four;
        logic fan_three;
        logic fan_two;
        logic fan_one;
        logic overtemp;
    } hpt_fault_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hpt_regreq_s;

    typedef enum logic [1:0] {
        HPT_HOT_IDLE = 2'b01,
        HPT_HOT_ACTIVE = 2'b10
    } hpt_hot_e;

endpackage

// [rtl/hpt_sync.sv]
// Two-stage synchroniser for the hot signal pin
`timescale 1ns/1ps
module hpt_sync (
    input wire logic clk_i, // System clock
    input wire logic reset_n_i, // Synchronous reset
    input wire logic d_i, // Asynchronous level
    output logic q_o // Synchronised level
);
    logic meta_reg;

    // Resets high: an idle pin reads as negated
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meta_reg <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule // hpt_sync

// [rtl/hpt_top.sv]
// Hot pin assertion timer, status flags, fan boost and alert routing
// Notes on behaviour
// - Mask bits 7,6,1 gate diode, overtemp alerts
// - Mask bits 4..2 fans; bit 5 fan four/hot
// - Alert output disabled after reset
// - Select bits route alert onto either pin
// - Config3 bit 1 enables hot pin monitoring
// - Boost forces full duty while pin low
// - Boost only for fans already running
// - Boost cleared leaves fans at settings
// - Timer counts while asserted, holds otherwise
// - Timer read clears; saturates at full scale
// - Bit 0 first; then 22.76 ms steps
// - Read during assertion restarts with bit 0
// - Limit zero read during assertion sets flag
// - Timer above limit sets status bit 5
// - Masked limit event still sets status
// - Limit zero alerts on first assertion
// - Status flags sticky until read, condition gone
// - Alert holds until source clears and read
`timescale 1ns/1ps
`include "hpt_defines.svh"
module hpt_top #(
    parameter int NUM_FANS = 3,
    parameter int UNIT_CYCLES =
        int'(`HPT_TIMER_LSB_MS * `HPT_CLK_MHZ * 1000.0)
) (
    input wire logic clk_i, // 20 MHz clock
    input wire logic reset_n_i, // Sync reset, low
    input wire hpt_pkg::hpt_regreq_s reg_req_i, // Register access
    output logic [7:0] reg_rdata_o, // Read data
    output logic reg_rvalid_o, // Read data valid
    input wire logic hot_n_i, // Hot pin, low active
    input wire hpt_pkg::hpt_fault_s fault_i, // Fault levels
    input wire logic [NUM_FANS-1:0] fan_manual_i, // Manual mode
    input wire logic [NUM_FANS*8-1:0] fan_duty_i, // Manual duties
    input wire logic [NUM_FANS-1:0] fan_above_start_temp_i, // Auto running
    output logic [NUM_FANS-1:0] fan_boost_o, // Force full duty
    output logic alert_pin_o, // Alternate pin level
    output logic alert_pin_oe_o, // Alternate pin drive
    output logic alert_vpin_o, // Voltage pin level
    output logic alert_vpin_oe_o // Voltage pin drive
);
    localparam int PW = $clog2(UNIT_CYCLES + 1);
    localparam logic [7:0] ST_RST = `HPT_STATUS2_RST;

    if (NUM_FANS < 1 || NUM_FANS > 8) begin : g_bad_fans
        $error("NUM_FANS must be 1 to 8");
    end
    if (UNIT_CYCLES < 2) begin : g_bad_unit
        $error("UNIT_CYCLES must be at least 2");
    end

    logic [7:0] mask2_reg;
    logic [7:0] config3_reg;
    logic [7:0] limit_reg;
    logic [7:0] vpin_sel_reg;
    logic [7:0] status_reg;
    logic [7:0] units_reg;
    logic [PW-1:0] pre_reg;
    logic seen_reg;
    hpt_pkg::hpt_hot_e hot_reg;
    hpt_pkg::hpt_hot_e hot_next;
    logic hot_sync_n;
    logic hot_act;
    logic hot_en;
    logic wr_hit;
    logic tm_rd;
    logic st_rd;
    logic [7:0] timer_val;
    logic exceed;
    logic [7:0] cond;
    logic alert_next;
    logic [7:0] rdata_next;

    assign hot_en = config3_reg[`HPT_C3_HOT_EN];
    assign wr_hit = reg_req_i.wr;
    assign tm_rd = reg_req_i.rd && reg_req_i.addr == `HPT_ADDR_TIMER;
    assign st_rd = reg_req_i.rd && reg_req_i.addr == `HPT_ADDR_STATUS2;

    hpt_sync u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .d_i(hot_n_i),
        .q_o(hot_sync_n)
    );

    // Writable registers; the timer and status are read only
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mask2_reg <= `HPT_MASK2_RST;
            config3_reg <= `HPT_CONFIG3_RST;
            limit_reg <= `HPT_LIMIT_RST;
            vpin_sel_reg <= `HPT_VPIN_SEL_RST;
        end else if (wr_hit) begin
            case (reg_req_i.addr)
                `HPT_ADDR_MASK2: mask2_reg <= reg_req_i.wdata;
                `HPT_ADDR_CONFIG3: config3_reg <= reg_req_i.wdata;
                `HPT_ADDR_LIMIT: limit_reg <= reg_req_i.wdata;
                `HPT_ADDR_VPIN_SEL: vpin_sel_reg <= reg_req_i.wdata;
                default: ;
            endcase
        end
    end

    // Pin state; only tracked while the pin has its hot role
    always_comb begin
        case (hot_reg)
            hpt_pkg::HPT_HOT_IDLE:
                hot_next = (hot_en && !hot_sync_n) ?
                    hpt_pkg::HPT_HOT_ACTIVE : hpt_pkg::HPT_HOT_IDLE;
            hpt_pkg::HPT_HOT_ACTIVE:
                hot_next = (hot_en && !hot_sync_n) ?
                    hpt_pkg::HPT_HOT_ACTIVE : hpt_pkg::HPT_HOT_IDLE;
            default: hot_next = hpt_pkg::HPT_HOT_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i)
            hot_reg <= hpt_pkg::HPT_HOT_IDLE;
        else
            hot_reg <= hot_next;
    end

    assign hot_act = hot_reg == hpt_pkg::HPT_HOT_ACTIVE;

    // Cumulative timer in 22.76 ms units plus a first-assertion mark
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pre_reg <= '0;
            units_reg <= 8'h00;
            seen_reg <= 1'b0;
        end else if (tm_rd) begin
            pre_reg <= '0;
            units_reg <= 8'h00;
            seen_reg <= hot_act;
        end else if (hot_act) begin
            seen_reg <= 1'b1;
            if (units_reg != `HPT_TIMER_FULL) begin
                if (pre_reg == PW'(UNIT_CYCLES - 1)) begin
                    pre_reg <= '0;
                    units_reg <= units_reg + 8'h01;
                end else begin
                    pre_reg <= pre_reg + PW'(1);
                end
            end
        end
    end

    // Below two units only the first-assertion mark shows
    assign timer_val = (units_reg >= `HPT_TIMER_STEP_UNITS) ?
        units_reg : {7'h00, seen_reg};
    assign exceed = timer_val > limit_reg;

    assign cond = {fault_i.diode_two, fault_i.diode_one,
        hot_en ? exceed : fault_i.fan_four,
        fault_i.fan_three, fault_i.fan_two, fault_i.fan_one,
        fault_i.overtemp, 1'b0};

    // Sticky flags: a live condition beats a clearing read
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_status
            always_ff @(posedge clk_i) begin
                if (!reset_n_i)
                    status_reg[b] <= ST_RST[b];
                else if (cond[b])
                    status_reg[b] <= 1'b1;
                else if (st_rd)
                    status_reg[b] <= 1'b0;
            end
        end
    endgenerate

    // Mask gates only the alert, never the flag
    assign alert_next = |(status_reg & ~mask2_reg);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            alert_pin_o <= 1'b0;
            alert_pin_oe_o <= 1'b0;
            alert_vpin_o <= 1'b0;
            alert_vpin_oe_o <= 1'b0;
        end else begin
            alert_pin_o <= 1'b0;
            alert_vpin_o <= 1'b0;
            alert_pin_oe_o <= alert_next &&
                config3_reg[`HPT_C3_ALERT_EN];
            alert_vpin_oe_o <= alert_next &&
                vpin_sel_reg[`HPT_VP_ALERT_EN];
        end
    end

    // Boost per fan; a stopped fan is left stopped
    genvar f;
    generate
        for (f = 0; f < NUM_FANS; f++) begin : g_fan
            logic running;
            assign running = fan_manual_i[f] ?
                (fan_duty_i[f*8 +: 8] != `HPT_DUTY_OFF) :
                fan_above_start_temp_i[f];
            always_ff @(posedge clk_i) begin
                if (!reset_n_i)
                    fan_boost_o[f] <= 1'b0;
                else
                    fan_boost_o[f] <= config3_reg[`HPT_C3_BOOST] &&
                        hot_act && running;
            end

            boost_stop_a: assert property (
                @(posedge clk_i) disable iff (!reset_n_i)
                fan_manual_i[f] && fan_duty_i[f*8 +: 8] == `HPT_DUTY_OFF
                |=> !fan_boost_o[f])
                else $error("stopped fan was boosted");
        end
    endgenerate

    always_comb begin
        case (reg_req_i.addr)
            `HPT_ADDR_STATUS2: rdata_next = status_reg;
            `HPT_ADDR_MASK2: rdata_next = mask2_reg;
            `HPT_ADDR_CONFIG3: rdata_next = config3_reg;
            `HPT_ADDR_TIMER: rdata_next = timer_val;
            `HPT_ADDR_LIMIT: rdata_next = limit_reg;
            `HPT_ADDR_VPIN_SEL: rdata_next = vpin_sel_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data captured in the same cycle as the clearing side effects
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd)
                reg_rdata_o <= rdata_next;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_pin_low;
        !hot_n_i;
    endsequence

    sequence s_sync_low;
        ##2 !hot_sync_n;
    endsequence

    sequence s_fresh_assert;
        hot_act && !seen_reg && units_reg == 8'h00 && !tm_rd;
    endsequence

    sequence s_read_live;
        tm_rd && hot_act && limit_reg == 8'h00;
    endsequence

    sync_two_stage_a: assert property (
        s_pin_low |-> s_sync_low)
        else $error("hot pin not seen two cycles later");

    mask_gate_a: assert property (
        (status_reg & ~mask2_reg) == 8'h00 |=>
            !alert_pin_oe_o && !alert_vpin_oe_o)
        else $error("masked source drove alert");

    alert_drive_a: assert property (
        (|(status_reg & ~mask2_reg)) &&
            config3_reg[`HPT_C3_ALERT_EN] |=> alert_pin_oe_o)
        else $error("unmasked flag did not drive alert");

    alert_enable_a: assert property (
        !config3_reg[`HPT_C3_ALERT_EN] |=> !alert_pin_oe_o)
        else $error("alert driven while disabled");

    vpin_route_a: assert property (
        alert_next && vpin_sel_reg[`HPT_VP_ALERT_EN]
            |=> alert_vpin_oe_o)
        else $error("voltage pin alert not routed");

    boost_run_a: assert property (
        config3_reg[`HPT_C3_BOOST] && hot_act &&
            (fan_manual_i[0] ? fan_duty_i[7:0] != `HPT_DUTY_OFF :
            fan_above_start_temp_i[0]) |=> fan_boost_o[0])
        else $error("running fan not boosted");

    boost_off_a: assert property (
        !config3_reg[`HPT_C3_BOOST] |=> fan_boost_o == '0)
        else $error("boost with boost bit clear");

    timer_hold_a: assert property (
        !hot_act && !tm_rd |=> $stable(units_reg) && $stable(pre_reg))
        else $error("timer moved while pin negated");

    timer_sat_a: assert property (
        units_reg == `HPT_TIMER_FULL && !tm_rd
            |=> units_reg == `HPT_TIMER_FULL)
        else $error("timer left full scale without read");

    first_mark_a: assert property (
        s_fresh_assert |=> timer_val == `HPT_TIMER_FIRST)
        else $error("first assertion did not set bit 0");

    step_two_a: assert property (
        hot_act && !tm_rd && units_reg == 8'h01 &&
            pre_reg == PW'(UNIT_CYCLES - 1)
            |=> timer_val == `HPT_TIMER_STEP_UNITS)
        else $error("second unit did not give value two");

    read_live_a: assert property (
        tm_rd && hot_act |=> timer_val == `HPT_TIMER_FIRST)
        else $error("read during assertion lost bit 0");

    limit_zero_a: assert property (
        s_read_live |-> ##2 status_reg[`HPT_ST_FAN_FOUR_HOT])
        else $error("limit zero read did not set flag");

    status_sticky_a: assert property (
        !st_rd |=> (status_reg & $past(status_reg)) ==
            $past(status_reg))
        else $error("status flag cleared without read");

    limit_flag_a: assert property (
        hot_en && exceed |=> status_reg[`HPT_ST_FAN_FOUR_HOT])
        else $error("limit exceed did not set flag");

    read_clear_a: assert property (
        tm_rd && !hot_act |=> timer_val == 8'h00)
        else $error("timer read did not clear count");

    status_clear_a: assert property (
        st_rd && cond == 8'h00 |=> status_reg == 8'h00)
        else $error("status read left a flag set");

    boost_idle_a: assert property (
        !hot_act |=> fan_boost_o == '0)
        else $error("boost while hot pin negated");

endmodule // hpt_top

// [tb/hpt_cpu_hot_model.sv]
// Model of the processor's open-drain hot output feeding the hot pin
`timescale 1ns/1ps
module hpt_cpu_hot_model (
    input wire logic clk_i, // System clock
    input wire logic hot_req_i, // Bench asks the processor to run hot
    output logic hot_n_o // Pin level as seen at the device
);
    logic drive_low_reg;

    // The processor changes its output only after a clock edge
    always_ff @(posedge clk_i) begin
        drive_low_reg <= hot_req_i;
    end

    // Released pin is pulled up, so it reads negated
    assign hot_n_o = drive_low_reg ? 1'b0 : 1'b1;
endmodule // hpt_cpu_hot_model

// [tb/hot_pin_timer_alert_logic_tb.sv]
// Self-checking bench for the hot pin timer and alert logic
`timescale 1ns/1ps
`include "hpt_defines.svh"
module hot_pin_timer_alert_logic_tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    hpt_pkg::hpt_regreq_s req = '0;
    hpt_pkg::hpt_fault_s fault = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic hot_req = 1'b0;
    logic hot_n;
    logic [2:0] boost;
    logic pin_oe;
    logic vpin_oe;
    logic pin_lvl;
    logic vpin_lvl;
    logic [7:0] addrs [5] = '{8'h75, 8'h78, 8'h7A, 8'h7D, 8'h42};
    int failures = 0;
    int checked = 0;

    always #25 clk_i = ~clk_i;

    hpt_cpu_hot_model cpu (
        .clk_i(clk_i),
        .hot_req_i(hot_req),
        .hot_n_o(hot_n)
    );

    // Short timer unit keeps saturation within about a thousand cycles
    hpt_top #(.NUM_FANS(3), .UNIT_CYCLES(4)) dut (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .reg_req_i(req),
        .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid),
        .hot_n_i(hot_n),
        .fault_i(fault),
        .fan_manual_i(3'b011),
        .fan_duty_i(24'h000080),
        .fan_above_start_temp_i(3'b100),
        .fan_boost_o(boost),
        .alert_pin_o(pin_lvl),
        .alert_pin_oe_o(pin_oe),
        .alert_vpin_o(vpin_lvl),
        .alert_vpin_oe_o(vpin_oe)
    );

    task automatic results();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Idle cycle after each access so wr/rd never toggle twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        cyc(1);
        req.wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req.addr = a;
        req.rd = 1'b1;
        cyc(1);
        req.rd = 1'b0;
        d = rvalid ? rdata : 8'hXX;
        cyc(1);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    task automatic hot_for(input int n);
        hot_req = 1'b1;
        cyc(n);
    endtask

    initial begin
        #500_000;
        failures++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        cyc(3);
        check({4'h0, pin_lvl, vpin_lvl, pin_oe, vpin_oe}, 8'h00);
        foreach (addrs[i]) rdchk(addrs[i], 8'h00);
        rdchk(8'h10, 8'h00);
        // Pin ignored while its role is off
        hot_for(20);
        hot_req = 1'b0;
        cyc(6);
        rdchk(`HPT_ADDR_TIMER, 8'h00);
        // Cumulative count over two bursts, limit one unit
        wr(`HPT_ADDR_LIMIT, 8'h01);
        wr(`HPT_ADDR_CONFIG3, 8'h07);
        hot_for(7);
        check({5'h00, boost}, 8'h05);
        hot_req = 1'b0;
        cyc(6);
        check({5'h00, boost}, 8'h00);
        check({7'h00, pin_oe}, 8'h00);
        hot_for(7);
        hot_req = 1'b0;
        cyc(6);
        check({6'h00, pin_lvl, pin_oe}, 8'h01);
        rdchk(`HPT_ADDR_TIMER, 8'h03);
        rdchk(`HPT_ADDR_TIMER, 8'h00);
        check({7'h00, pin_oe}, 8'h01);
        rdchk(`HPT_ADDR_STATUS2, 8'h20);
        cyc(2);
        check({7'h00, pin_oe}, 8'h00);
        rdchk(`HPT_ADDR_STATUS2, 8'h00);
        // Masked limit event, saturation, read during assertion
        wr(`HPT_ADDR_LIMIT, 8'h00);
        wr(`HPT_ADDR_MASK2, 8'h20);
        wr(`HPT_ADDR_CONFIG3, 8'h03);
        hot_for(1100);
        check({7'h00, pin_oe}, 8'h00);
        check({5'h00, boost}, 8'h00);
        rdchk(`HPT_ADDR_STATUS2, 8'h20);
        rdchk(`HPT_ADDR_TIMER, 8'hFF);
        rdchk(`HPT_ADDR_TIMER, 8'h01);
        rdchk(`HPT_ADDR_STATUS2, 8'h20);
        hot_req = 1'b0;
        cyc(6);
        // Route the pending alert onto the voltage pin instead
        wr(`HPT_ADDR_CONFIG3, 8'h02);
        wr(`HPT_ADDR_VPIN_SEL, 8'h01);
        wr(`HPT_ADDR_MASK2, 8'h00);
        cyc(2);
        check({4'h0, pin_lvl, vpin_lvl, pin_oe, vpin_oe}, 8'h01);
        rdchk(`HPT_ADDR_TIMER, 8'h01);
        rdchk(`HPT_ADDR_STATUS2, 8'h20);
        rdchk(`HPT_ADDR_STATUS2, 8'h00);
        cyc(2);
        check({7'h00, vpin_oe}, 8'h00);
        // Each fault source: masked, then unmasked, then cleared
        wr(`HPT_ADDR_VPIN_SEL, 8'h00);
        wr(`HPT_ADDR_CONFIG3, 8'h01);
        for (int b = 1; b < 8; b++) begin
            wr(`HPT_ADDR_MASK2, 8'h01 << b);
            fault = hpt_pkg::hpt_fault_s'(7'h01 << (b - 1));
            cyc(3);
            check({7'h00, pin_oe}, 8'h00);
            wr(`HPT_ADDR_MASK2, 8'h00);
            cyc(3);
            check({7'h00, pin_oe}, 8'h01);
            fault = '0;
            cyc(2);
            rdchk(`HPT_ADDR_STATUS2, 8'h01 << b);
            rdchk(`HPT_ADDR_STATUS2, 8'h00);
            cyc(2);
            check({7'h00, pin_oe}, 8'h00);
        end
        results();
    end
endmodule // hot_pin_timer_alert_logic_tb
